// ---- shared/flxa_defines.vh ----
`ifndef FLXA_DEFINES_VH
`define FLXA_DEFINES_VH

// ============================================================
// register byte addresses on the APB
`define FLXA_ADDR_ACCESS_CTRL   32'h007FC090
`define FLXA_ADDR_STARTUP_MON   32'h007FC0B0
`define FLXA_ADDR_COMMAND       32'h007FC0C0
`define FLXA_ADDR_START_ADDR    32'h007FC0C4
`define FLXA_ADDR_END_ADDR      32'h007FC0C8
`define FLXA_ADDR_STATUS        32'h007FC0CC
`define FLXA_ADDR_READ_BUF      32'h007FC0D0

// ============================================================
// field positions
`define FLXA_ACC_EN_BIT         0
`define FLXA_CMD_MSB            3
`define FLXA_CMD_LSB            0
`define FLXA_DRC_BIT            4
`define FLXA_ST_READY_BIT       0
`define FLXA_ST_READ_DATA_READY_FLAG_BIT       1
`define FLXA_ST_ERR_BIT         2

// ============================================================
// command codes
`define FLXA_CMD_PROGRAM        4'h1
`define FLXA_CMD_BLANK_CHECK    4'h3
`define FLXA_CMD_BLOCK_ERASE    4'h4
`define FLXA_CMD_UID_READ       4'h5
`define FLXA_CMD_SET_WINDOW     4'h6
`define FLXA_CMD_STARTUP_PROG   4'h7

// ============================================================
// extra-area identifier range and reset values
`define FLXA_UID_FIRST          16'h0850
`define FLXA_UID_LAST           16'h086F
`define FLXA_UID_STEP           16'h0004
`define FLXA_RST_ACCESS_CTRL    1'h0
`define FLXA_RST_ADDR           16'h0000

`endif

// ---- rtl/flxa_id_rom.v ----
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// per-chip identifier store: 8 words of 4 bytes, no write path
module flxa_id_rom #(
    // arbitrary neutral value; the real part takes it from fuses
    parameter [255:0] ID_VALUE = 256'h1F1E1D1C1B1A191817161514131211100F0E0D0C0B0A09080706050403020100
) (
    input  wire        i_core_clk,
    input  wire [2:0]  i_word,
    output reg  [31:0] o_data
);
    wire [31:0] words [0:7];

    genvar w;
    generate
        for (w = 0; w < 8; w = w + 1) begin : g_word
            // byte n sits at 0850h+n, so word w holds bytes 4w..4w+3, lowest byte in the low lane
            assign words[w] = ID_VALUE[32*w +: 32];
        end
    endgenerate

    always @(posedge i_core_clk) begin
        o_data <= words[i_word];
    end
endmodule // flxa_id_rom

`default_nettype wire

// ---- rtl/flxa_access_top.v ----
// Summary of operation
// - enable bit zero gates extra-area access
// - bits seven to one read zero
// - enable governs identifier read, window setting and startup programming
// - 32-byte identifier at 0850h to 086Fh
// - software cannot program or erase identifier
// - sequencer accepts six listed commands
// - control register 8-bit, 2-3 cycles
// - monitor register 16-bit, 2-3 cycles
// - identifier read walks start to end
// - reissue with completion 0 adds 4
// - data-ready rises on load, clears on completion
// - upper half high buffer, lower half low
`timescale 1ns/1ns
`default_nettype none
`include "flxa_defines.vh"

module flxa_access_top (
    input  wire        i_core_clk,
    input  wire        i_rst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [31:0] i_paddr,
    input  wire [31:0] i_pwdata,
    input  wire [15:0] i_startup_setting,
    input  wire        i_array_done,
    output wire        o_pready,
    output reg  [31:0] o_prdata,
    output wire        o_pslverr,
    output reg         o_array_req,
    output reg  [3:0]  o_array_cmd,
    output reg  [15:0] o_array_start,
    output reg  [15:0] o_array_end
);
    // ============================================================
    // states
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_FETCH = 3'h1;
    localparam [2:0] ST_LOAD  = 3'h2;
    localparam [2:0] ST_HOLD  = 3'h3;
    localparam [2:0] ST_ARRAY = 3'h4;

    reg        access_enable;
    reg [15:0] startup_monitor;
    reg [3:0]  command;
    reg        read_completion_bit;
    reg [15:0] start_address_high;
    reg [15:0] start_address_low;
    reg [15:0] end_address_high;
    reg [15:0] end_address_low;
    reg [15:0] read_buffer_high;
    reg [15:0] read_buffer_low;
    reg        read_data_ready_flag;
    reg        cmd_error;
    reg [2:0]  state;
    reg [15:0] seq_addr;
    reg [15:0] next_seq_addr;
    reg        in_read_cycle;

    wire [31:0] rom_data;

    // ============================================================
    // bus decode
    wire access_phase = i_psel & i_penable;
    wire hit_ctrl  = (i_paddr == `FLXA_ADDR_ACCESS_CTRL);
    wire hit_mon   = (i_paddr == `FLXA_ADDR_STARTUP_MON);
    wire hit_cmd   = (i_paddr == `FLXA_ADDR_COMMAND);
    wire hit_start = (i_paddr == `FLXA_ADDR_START_ADDR);
    wire hit_end   = (i_paddr == `FLXA_ADDR_END_ADDR);
    wire hit_stat  = (i_paddr == `FLXA_ADDR_STATUS);
    wire hit_buf   = (i_paddr == `FLXA_ADDR_READ_BUF);
    wire hit_any   = hit_ctrl | hit_mon | hit_cmd | hit_start | hit_end | hit_stat | hit_buf;
    // read-only registers refuse writes with an error, as do holes
    wire bad_write = i_pwrite & (hit_mon | hit_stat | hit_buf);

    assign o_pready  = 1'b1;
    assign o_pslverr = access_phase & (~hit_any | bad_write);

    wire wr_ok  = access_phase & i_pwrite & hit_any & ~bad_write;
    wire cmd_wr = wr_ok & hit_cmd;
    wire seq_ready = (state == ST_IDLE) | (state == ST_HOLD);

    // ============================================================
    // command classification
    wire [3:0] wr_cmd = i_pwdata[`FLXA_CMD_MSB:`FLXA_CMD_LSB];
    wire       wr_drc = i_pwdata[`FLXA_DRC_BIT];
    wire is_uid    = (wr_cmd == `FLXA_CMD_UID_READ);
    wire is_extra  = (wr_cmd == `FLXA_CMD_SET_WINDOW) | (wr_cmd == `FLXA_CMD_STARTUP_PROG);
    wire is_modify = (wr_cmd == `FLXA_CMD_PROGRAM) | (wr_cmd == `FLXA_CMD_BLOCK_ERASE);
    wire is_blank  = (wr_cmd == `FLXA_CMD_BLANK_CHECK);
    wire is_known  = is_uid | is_extra | is_modify | is_blank;
    // no modify may touch the identifier range
    wire hits_uid  = (start_address_low <= `FLXA_UID_LAST) & (end_address_low >= `FLXA_UID_FIRST)
                     & (start_address_high == 16'h0000);
    wire uid_range_ok = (start_address_high == 16'h0000) & (end_address_high == 16'h0000)
                        & (start_address_low >= `FLXA_UID_FIRST) & (end_address_low <= `FLXA_UID_LAST);
    // extra-area operations need the enable bit
    wire refuse = ~is_known
                  | ((is_uid | is_extra) & ~access_enable)
                  | (is_modify & hits_uid)
                  | (is_uid & ~wr_drc & ~in_read_cycle & ~uid_range_ok);
    // a command written while a fetch or array job runs is dropped
    wire accept = cmd_wr & seq_ready & (wr_cmd != 4'h0);

    // next word on a reissue, first word otherwise
    always @* begin
        if (in_read_cycle) begin
            next_seq_addr = seq_addr + `FLXA_UID_STEP;
        end else begin
            next_seq_addr = start_address_low;
        end
    end
    wire past_end = (next_seq_addr > end_address_low);

    // ============================================================
    // register writes
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            access_enable      <= `FLXA_RST_ACCESS_CTRL;
            start_address_high <= `FLXA_RST_ADDR;
            start_address_low  <= `FLXA_RST_ADDR;
            end_address_high   <= `FLXA_RST_ADDR;
            end_address_low    <= `FLXA_RST_ADDR;
            startup_monitor    <= 16'h0000;
        end else begin
            startup_monitor <= i_startup_setting;
            if (wr_ok & hit_ctrl) begin
                access_enable <= i_pwdata[`FLXA_ACC_EN_BIT];
            end
            if (wr_ok & hit_start & seq_ready) begin
                start_address_low  <= i_pwdata[15:0];
                start_address_high <= i_pwdata[31:16];
            end
            if (wr_ok & hit_end & seq_ready) begin
                end_address_low  <= i_pwdata[15:0];
                end_address_high <= i_pwdata[31:16];
            end
        end
    end

    // ============================================================
    // sequencer
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            state                <= ST_IDLE;
            command              <= 4'h0;
            read_completion_bit  <= 1'b0;
            seq_addr             <= `FLXA_RST_ADDR;
            in_read_cycle        <= 1'b0;
            read_data_ready_flag <= 1'b0;
            read_buffer_high     <= 16'h0000;
            read_buffer_low      <= 16'h0000;
            cmd_error            <= 1'b0;
            o_array_req          <= 1'b0;
            o_array_cmd          <= 4'h0;
            o_array_start        <= 16'h0000;
            o_array_end          <= 16'h0000;
        end else begin
            o_array_req <= 1'b0;
            case (state)
                ST_IDLE, ST_HOLD: begin
                    if (accept) begin
                        command             <= wr_cmd;
                        read_completion_bit <= wr_drc;
                        // error is cleared by the next accepted command, set by a refused one
                        cmd_error           <= refuse;
                        if (!refuse && is_uid) begin
                            if (wr_drc) begin
                                read_data_ready_flag <= 1'b0;
                                in_read_cycle        <= 1'b0;
                                state                <= ST_IDLE;
                            end else if (past_end) begin
                                // range exhausted: ready again, no new data
                                read_data_ready_flag <= 1'b0;
                                state                <= ST_HOLD;
                            end else begin
                                seq_addr             <= next_seq_addr;
                                in_read_cycle        <= 1'b1;
                                read_data_ready_flag <= 1'b0;
                                state                <= ST_FETCH;
                            end
                        end else if (!refuse) begin
                            o_array_req   <= 1'b1;
                            o_array_cmd   <= wr_cmd;
                            o_array_start <= start_address_low;
                            o_array_end   <= end_address_low;
                            state         <= ST_ARRAY;
                        end
                    end
                end
                ST_FETCH: begin
                    state <= ST_LOAD;
                end
                ST_LOAD: begin
                    // upper two bytes high, lower two bytes low
                    read_buffer_high     <= rom_data[31:16];
                    read_buffer_low      <= rom_data[15:0];
                    read_data_ready_flag <= 1'b1;
                    state                <= ST_HOLD;
                end
                ST_ARRAY: begin
                    if (i_array_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // identifier store
    wire [15:0] rom_offset = seq_addr - `FLXA_UID_FIRST;

    // bytes reachable only through the read command
    flxa_id_rom u_id_rom (
        .i_core_clk (i_core_clk),
        .i_word     (rom_offset[4:2]),
        .o_data     (rom_data)
    );

    // ============================================================
    // read mux, registered in the setup cycle
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            o_prdata <= 32'h00000000;
        end else if (i_psel & ~i_penable & ~i_pwrite) begin
            o_prdata <= 32'h00000000;
            if (hit_ctrl) begin
                o_prdata[`FLXA_ACC_EN_BIT] <= access_enable;
            end
            if (hit_mon) begin
                o_prdata[15:0] <= startup_monitor;
            end
            if (hit_cmd) begin
                o_prdata[`FLXA_CMD_MSB:`FLXA_CMD_LSB] <= command;
                o_prdata[`FLXA_DRC_BIT]               <= read_completion_bit;
            end
            if (hit_start) begin
                o_prdata <= {start_address_high, start_address_low};
            end
            if (hit_end) begin
                o_prdata <= {end_address_high, end_address_low};
            end
            if (hit_stat) begin
                o_prdata[`FLXA_ST_READY_BIT] <= seq_ready;
                o_prdata[`FLXA_ST_READ_DATA_READY_FLAG_BIT] <= read_data_ready_flag;
                o_prdata[`FLXA_ST_ERR_BIT]   <= cmd_error;
            end
            if (hit_buf) begin
                o_prdata <= {read_buffer_high, read_buffer_low};
            end
        end
    end
endmodule // flxa_access_top

`default_nettype wire

// ---- testbench/flxa_access_props_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "flxa_defines.vh"
// ============================================================
// port-level checks
module flxa_access_props (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [15:0] i_startup_setting,
    input wire logic        i_array_done,
    input wire logic        o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pslverr,
    input wire logic        o_array_req,
    input wire logic [3:0]  o_array_cmd,
    input wire logic [15:0] o_array_start,
    input wire logic [15:0] o_array_end
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic acc;
    logic rd_set;
    logic en_q;
    assign acc    = i_psel && i_penable;
    assign rd_set = i_psel && !i_penable && !i_pwrite;
    // last enable written, so gating can be judged without the body
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            en_q <= 1'b0;
        end else if (acc && i_pwrite && i_paddr == `FLXA_ADDR_ACCESS_CTRL) begin
            en_q <= i_pwdata[0];
        end
    end
    a_ready_access: assert property (acc |-> o_pready) else $error("pready low");
    a_monitor_ro: assert property (acc && i_pwrite && i_paddr == `FLXA_ADDR_STARTUP_MON |-> o_pslverr)
        else $error("monitor write accepted");
    a_ctrl_read: assert property (rd_set && i_paddr == `FLXA_ADDR_ACCESS_CTRL |=> o_prdata == {31'h0, en_q})
        else $error("ctrl read wrong");
    a_monitor_read: assert property (rd_set && i_paddr == `FLXA_ADDR_STARTUP_MON && $stable(i_startup_setting)
        |=> o_prdata == {16'h0000, $past(i_startup_setting)}) else $error("monitor read wrong");
    a_req_pulse: assert property (o_array_req |=> !o_array_req) else $error("job request too long");
    a_req_listed: assert property (o_array_req |-> o_array_cmd inside {4'h1, 4'h3, 4'h4, 4'h6, 4'h7})
        else $error("unlisted job");
    a_id_protected: assert property (o_array_req && o_array_cmd inside {4'h1, 4'h4}
        |-> (o_array_end < `FLXA_UID_FIRST || o_array_start > `FLXA_UID_LAST)) else $error("id range touched");
    a_gate_jobs: assert property (o_array_req && o_array_cmd inside {4'h6, 4'h7} |-> en_q)
        else $error("job while disabled");
endmodule // flxa_access_props

bind flxa_access_top flxa_access_props flxa_access_props_i (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_startup_setting(i_startup_setting), .i_array_done(i_array_done),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_array_req(o_array_req),
    .o_array_cmd(o_array_cmd), .o_array_start(o_array_start), .o_array_end(o_array_end));
`default_nettype wire

// ---- testbench/flxa_access_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "flxa_defines.vh"
module flxa_access_top_tb;
    typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e; logic err;} flxa_row_t;
    logic        clk, rst, psel, penable, pwrite, done, er;
    logic [31:0] paddr, pwdata, rd;
    wire         pready, pslverr, req;
    wire  [31:0] prdata;
    wire  [3:0]  acmd;
    wire  [15:0] astart, aend;
    logic [15:0] sset;
    integer      failures = 0, total_checks = 0, req_cnt = 0, i, n0;
    flxa_row_t   rows [10];
    logic [3:0]  codes [5] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h7};
    logic [35:0] bad [5] = '{36'h108600860, 36'h408000850, 36'h1086F0900, 36'h210001000, 36'h50840086F};
    flxa_access_top flxa_access_top_i (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_startup_setting(sset),
        .i_array_done(done), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_array_req(req),
        .o_array_cmd(acmd), .o_array_start(astart), .o_array_end(aend));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (req === 1'b1) req_cnt <= req_cnt + 1;
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task end_of_test;
        if (failures == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // apb transfer: setup, then access held until pready
    // no limit of its own: a slave that never answers is caught by the watchdog
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task cmd(input logic [31:0] c);
        apb(1'b1, `FLXA_ADDR_COMMAND, c);
        rd = 32'h0;
        while (rd[0] !== 1'b1) begin
            apb(1'b0, `FLXA_ADDR_STATUS, 32'h0);
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_of_test;
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        done = 1'b0;
        sset = 16'hA5C3;
        rows = '{'{1'b0, `FLXA_ADDR_ACCESS_CTRL, 32'h0, 32'h0, 1'b0},
                 '{1'b1, `FLXA_ADDR_ACCESS_CTRL, 32'h1, 32'h0, 1'b0},
                 '{1'b0, `FLXA_ADDR_ACCESS_CTRL, 32'h0, 32'h1, 1'b0},
                 '{1'b1, `FLXA_ADDR_ACCESS_CTRL, 32'h0, 32'h0, 1'b0},
                 '{1'b0, `FLXA_ADDR_ACCESS_CTRL, 32'h0, 32'h0, 1'b0},
                 '{1'b0, `FLXA_ADDR_STARTUP_MON, 32'h0, 32'hA5C3, 1'b0},
                 '{1'b1, `FLXA_ADDR_STARTUP_MON, 32'h1, 32'h0, 1'b1},
                 '{1'b1, `FLXA_ADDR_STATUS, 32'h1, 32'h0, 1'b1},
                 '{1'b1, `FLXA_ADDR_READ_BUF, 32'h1, 32'h0, 1'b1},
                 '{1'b0, 32'h007FC094, 32'h0, 32'h0, 1'b1}};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 10; i++) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("prdata", rows[i].e, rd);
            chk("pslverr", {31'h0, rows[i].err}, {31'h0, er});
        end
        // identifier walk, one word past the end
        apb(1'b1, `FLXA_ADDR_START_ADDR, 32'h0850);
        apb(1'b1, `FLXA_ADDR_END_ADDR, 32'h086F);
        apb(1'b1, `FLXA_ADDR_ACCESS_CTRL, 32'h1);
        for (i = 0; i < 9; i++) begin
            cmd(32'h05);
            chk("data ready", {31'h0, i < 8}, {31'h0, rd[1]});
            apb(1'b0, `FLXA_ADDR_READ_BUF, 32'h0);
            if (i < 8) chk("id word", 32'h03020100 + 32'h04040404 * i, rd);
        end
        cmd(32'h15);
        chk("data ready end", 32'h0, {31'h0, rd[1]});
        apb(1'b1, `FLXA_ADDR_ACCESS_CTRL, 32'h0);
        n0 = req_cnt;
        for (i = 5; i < 8; i++) begin
            cmd(i);
            chk("gated error", 32'h1, {31'h0, rd[2]});
        end
        chk("gated count", n0, req_cnt);
        apb(1'b1, `FLXA_ADDR_ACCESS_CTRL, 32'h1);
        apb(1'b1, `FLXA_ADDR_START_ADDR, 32'h1000);
        apb(1'b1, `FLXA_ADDR_END_ADDR, 32'h10FF);
        for (i = 0; i < 5; i++) begin
            n0 = req_cnt;
            apb(1'b1, `FLXA_ADDR_COMMAND, {28'h0, codes[i]});
            repeat (3) @(posedge clk);
            chk("job count", n0 + 1, req_cnt);
            chk("job cmd", {28'h0, codes[i]}, {28'h0, acmd});
            chk("job start", 32'h1000, {16'h0, astart});
            chk("job end", 32'h10FF, {16'h0, aend});
            done <= 1'b1;
            @(posedge clk);
            done <= 1'b0;
            cmd(32'h0);
        end
        // refusals: protected range, unknown code, identifier read out of range
        for (i = 0; i < 5; i++) begin
            n0 = req_cnt;
            apb(1'b1, `FLXA_ADDR_START_ADDR, {16'h0, bad[i][31:16]});
            apb(1'b1, `FLXA_ADDR_END_ADDR, {16'h0, bad[i][15:0]});
            cmd({28'h0, bad[i][35:32]});
            chk("refused error", 32'h1, {31'h0, rd[2]});
            chk("refused count", n0, req_cnt);
        end
        // monitor follows its input; a fresh read after completion starts at the start address
        sset <= 16'h3C5A;
        apb(1'b0, `FLXA_ADDR_STARTUP_MON, 32'h0);
        chk("monitor live", 32'h00003C5A, rd);
        apb(1'b1, `FLXA_ADDR_START_ADDR, 32'h0850);
        apb(1'b1, `FLXA_ADDR_END_ADDR, 32'h086F);
        cmd(32'h05);
        chk("restart ready", 32'h1, {31'h0, rd[1]});
        apb(1'b0, `FLXA_ADDR_READ_BUF, 32'h0);
        chk("restart word", 32'h03020100, rd);
        cmd(32'h15);
        chk("ready cleared", 32'h0, {31'h0, rd[1]});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `FLXA_ADDR_ACCESS_CTRL, 32'h0);
        chk("ctrl after reset", 32'h0, rd);
        end_of_test;
    end
endmodule // flxa_access_top_tb
`default_nettype wire
